// >>> hw/lsw_flp_engine.sv
// Receives and sends negotiation pulse bursts of clock and data positions.
`timescale 1ns/1ps
`include "lsw_map.svh"
module lsw_flp_engine
    import lsw_pkg::*;
#(
    parameter int SLOT_CYC = `LSW_SLOT_CYC,
    parameter int GAP_CYC  = `LSW_GAP_CYC
) (
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    input  wire logic clk_pulse_in,
    input  wire logic data_pulse_in,
    lsw_flp_if.eng    flp
);

    lsw_eng_state_type s_r;
    lsw_eng_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rx_valid = 1'b0;
        s_nxt.tx_pulse = 1'b0;
        // Receive: a data pulse between two clock pulses is a one bit, first bit lowest.
        if (s_r.rx_cnt != 5'h00) begin
            s_nxt.rx_timer = s_r.rx_timer + 16'h0001;
            if (data_pulse_in) begin
                s_nxt.rx_seen = 1'b1;
            end
        end
        if (clk_pulse_in) begin
            s_nxt.rx_timer = 16'h0000;
            s_nxt.rx_seen = 1'b0;
            if (s_r.rx_cnt == 5'h00) begin
                s_nxt.rx_cnt = 5'h01;
                s_nxt.rx_pulses = 6'h01;
                s_nxt.rx_word = 16'h0000;
            end else begin
                s_nxt.rx_word = {s_r.rx_seen, s_r.rx_word[15:1]};
                s_nxt.rx_pulses = s_r.rx_pulses + 6'h01 + {5'h00, s_r.rx_seen};
                if (s_r.rx_cnt == `LSW_FLP_CLOCKS - 5'h01) begin
                    s_nxt.rx_valid = 1'b1;
                    s_nxt.rx_cnt = 5'h00;
                end else begin
                    s_nxt.rx_cnt = s_r.rx_cnt + 5'h01;
                end
            end
        end else if (s_r.rx_cnt != 5'h00 && s_r.rx_timer >= 16'(GAP_CYC)) begin
            // A burst that stalls is dropped whole; a partial word is never used.
            s_nxt.rx_cnt = 5'h00;
        end
        // Transmit: even slots carry clock pulses, odd slots the data bits.
        if (!s_r.tx_busy) begin
            if (flp.tx_start) begin
                s_nxt.tx_busy = 1'b1;
                s_nxt.tx_slot = 6'h00;
                s_nxt.tx_timer = 16'h0000;
                s_nxt.tx_word = flp.tx_word;
                s_nxt.tx_pulse = 1'b1;
            end
        end else if (s_r.tx_timer == 16'(SLOT_CYC - 1)) begin
            s_nxt.tx_timer = 16'h0000;
            if (s_r.tx_slot == `LSW_FLP_LAST_SLOT) begin
                s_nxt.tx_busy = 1'b0;
            end else begin
                s_nxt.tx_slot = s_r.tx_slot + 6'h01;
                if (s_r.tx_slot[0]) begin
                    s_nxt.tx_pulse = 1'b1;
                end else begin
                    s_nxt.tx_pulse = s_r.tx_word[0];
                    s_nxt.tx_word = {1'b0, s_r.tx_word[15:1]};
                end
            end
        end else begin
            s_nxt.tx_timer = s_r.tx_timer + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign flp.rx_valid = s_r.rx_valid;
    assign flp.rx_word  = s_r.rx_word;
    assign flp.tx_busy  = s_r.tx_busy;
    assign flp.tx_pulse = s_r.tx_pulse;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    property p_rx_count;
        s_r.rx_valid |-> s_r.rx_pulses == 6'h11 + 6'($countones(s_r.rx_word));
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("burst pulse total wrong");

    property p_rx_max;
        s_r.rx_pulses <= `LSW_FLP_PULSES;
    endproperty
    a_rx_max: assert property (p_rx_max) else $error("more than 33 pulses");

    property p_tx_first;
        (!s_r.tx_busy && flp.tx_start) |=> s_r.tx_pulse && s_r.tx_busy && s_r.tx_slot == 6'h00;
    endproperty
    a_tx_first: assert property (p_tx_first) else $error("burst did not open with clock");

endmodule

// >>> hw/lsw_top.sv
// Link speed resolution, status indicators and wake-up signalling.
`timescale 1ns/1ps
`include "lsw_map.svh"
module lsw_top
    import lsw_pkg::*;
#(
    parameter int SLOT_CYC = `LSW_SLOT_CYC,
    parameter int GAP_CYC  = `LSW_GAP_CYC
) (
    input  wire logic                   ref_clk_in,
    input  wire logic                   rstn_in,
    input  wire logic [`LSW_ADDR_W-1:0] addr_in,
    input  wire logic [31:0]            wr_data_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic      [31:0]            rd_data_out,
    input  wire logic                   flp_clk_pulse_in,
    input  wire logic                   flp_data_pulse_in,
    output logic                        flp_tx_pulse_out,
    input  wire logic                   link_pass_in,
    input  wire logic                   par_link_in,
    input  wire logic                   par_speed100_in,
    input  wire logic                   rx_active_in,
    input  wire logic                   tx_active_in,
    input  wire logic                   collision_in,
    input  wire logic                   low_power_in,
    input  wire logic                   remote_wake_pkt_in,
    input  wire logic                   wake_frame_in,
    input  wire logic                   pme_ack_in,
    output logic                        link_ok_indicator_out,
    output logic                        traffic_indicator_out,
    output logic                        speed_indicator_out,
    output logic                        collision_or_wake_mode_indicator_out,
    output logic                        pme_n_out,
    output logic                        pme_n_oe_out,
    output logic                        wake_conn_out,
    output logic                        speed100_out,
    output logic                        full_duplex_out,
    output logic                        irq_out
);

    lsw_flp_if flp ();

    lsw_flp_engine #(
        .SLOT_CYC (SLOT_CYC),
        .GAP_CYC  (GAP_CYC)
    ) u_engine (
        .ref_clk_in    (ref_clk_in),
        .rstn_in       (rstn_in),
        .clk_pulse_in  (flp_clk_pulse_in),
        .data_pulse_in (flp_data_pulse_in),
        .flp           (flp)
    );

    localparam lsw_top_state_type RESET_STATE = '{
        an:          LSW_AN_IDLE,
        mode:        LSW_MODE_10HD,
        parallel:    1'b0,
        partner:     16'h0000,
        adv:         `LSW_ADV_RESET,
        pme_en:      1'b1,
        conn_en:     1'b1,
        link_prev:   1'b0,
        wake_pend:   1'b0,
        irq_stat:    3'h0,
        irq_mask:    3'h0,
        tx_start:    1'b0,
        rd_data:     32'h0000_0000,
        led_link:    1'b0,
        led_traffic: 1'b0,
        led_speed:   1'b0,
        led_mode:    1'b0,
        pme_oe:      1'b0,
        wake_conn:   1'b0,
        irq:         1'b0
    };

    lsw_top_state_type st_r;
    lsw_top_state_type st_nxt;

    logic       wr_ctrl;
    logic       wr_status;
    logic       wr_irq_stat;
    logic [3:0] common;
    logic       link_change;
    logic       wake_event;
    logic       an_done;
    logic       restart;
    logic       wake_armed;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    assign flp.tx_word = {7'h00, st_r.adv, `LSW_SELECTOR};
    assign flp.tx_start = st_r.tx_start;

    always_comb begin
        st_nxt = st_r;
        wr_ctrl = wr_in && addr_in == `LSW_REG_CTRL;
        wr_status = wr_in && addr_in == `LSW_REG_STATUS;
        wr_irq_stat = wr_in && addr_in == `LSW_REG_IRQ_STAT;
        restart = wr_ctrl && wr_data_in[`LSW_CTRL_RESTART];
        common = st_r.adv & flp.rx_word[`LSW_ABIL_LSB +: 4];
        link_change = link_pass_in != st_r.link_prev;
        wake_event = remote_wake_pkt_in || wake_frame_in || link_change;
        wake_armed = low_power_in && (st_r.pme_en || st_r.conn_en);
        an_done = 1'b0;
        st_nxt.tx_start = 1'b0;
        st_nxt.link_prev = link_pass_in;

        // Negotiation: repeat our burst until the partner answers with a shared ability or a link is detected.
        case (st_r.an)
            LSW_AN_IDLE: begin
                st_nxt.an = LSW_AN_LISTEN;
                st_nxt.parallel = 1'b0;
            end
            LSW_AN_LISTEN: begin
                st_nxt.tx_start = !flp.tx_busy && !st_r.tx_start;
                if (flp.rx_valid && common != 4'h0) begin
                    st_nxt.an = LSW_AN_RESOLVED;
                    st_nxt.partner = flp.rx_word;
                    an_done = 1'b1;
                    if (common[3]) begin
                        st_nxt.mode = LSW_MODE_TXFD;
                    end else if (common[2]) begin
                        st_nxt.mode = LSW_MODE_TXHD;
                    end else if (common[1]) begin
                        st_nxt.mode = LSW_MODE_10FD;
                    end else begin
                        st_nxt.mode = LSW_MODE_10HD;
                    end
                end else if (par_link_in) begin
                    // Duplex cannot be learned from a silent partner, so half is the safe choice.
                    st_nxt.an = LSW_AN_PARALLEL;
                    st_nxt.parallel = 1'b1;
                    an_done = 1'b1;
                    st_nxt.mode = par_speed100_in ? LSW_MODE_TXHD : LSW_MODE_10HD;
                end
            end
            default: begin
                if (st_r.link_prev && !link_pass_in) begin
                    st_nxt.an = LSW_AN_IDLE;
                end
            end
        endcase
        if (restart) begin
            st_nxt.an = LSW_AN_IDLE;
        end

        st_nxt.led_link = link_pass_in;
        st_nxt.led_traffic = rx_active_in || tx_active_in;
        st_nxt.led_speed = st_nxt.mode[1] && link_pass_in;
        if (low_power_in) begin
            st_nxt.led_mode = wake_armed;
        end else begin
            st_nxt.led_mode = collision_in;
        end

        // A new event in the cycle of an acknowledge keeps the wake raised.
        st_nxt.wake_pend = wake_event || (st_r.wake_pend && !pme_ack_in &&
                           !(wr_status && wr_data_in[`LSW_ST_WAKE]));
        st_nxt.pme_oe = st_nxt.wake_pend && st_r.pme_en;
        st_nxt.wake_conn = st_nxt.wake_pend && st_r.conn_en;

        if (wr_ctrl) begin
            st_nxt.adv = wr_data_in[`LSW_CTRL_ADV_LSB +: 4];
            st_nxt.pme_en = wr_data_in[`LSW_CTRL_PME_EN];
            st_nxt.conn_en = wr_data_in[`LSW_CTRL_CONN_EN];
        end
        if (wr_in && addr_in == `LSW_REG_IRQ_MASK) begin
            st_nxt.irq_mask = wr_data_in[`LSW_IRQ_W-1:0];
        end
        irq_set = 3'h0;
        irq_set[`LSW_IRQ_LINK] = link_change;
        irq_set[`LSW_IRQ_AN] = an_done;
        irq_set[`LSW_IRQ_WAKE] = wake_event;
        irq_clr = wr_irq_stat ? wr_data_in[`LSW_IRQ_W-1:0] : 3'h0;
        st_nxt.irq_stat = irq_set | (st_r.irq_stat & ~irq_clr);
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

        st_nxt.rd_data = 32'h0000_0000;
        if (rd_in) begin
            if (addr_in == `LSW_REG_CTRL) begin
                st_nxt.rd_data = {26'h0, st_r.conn_en, st_r.pme_en, st_r.adv};
            end else if (addr_in == `LSW_REG_STATUS) begin
                st_nxt.rd_data = {25'h0, st_r.an, st_r.wake_pend, st_r.parallel,
                                  st_r.mode, link_pass_in};
            end else if (addr_in == `LSW_REG_IRQ_STAT) begin
                st_nxt.rd_data = {29'h0, st_r.irq_stat};
            end else if (addr_in == `LSW_REG_IRQ_MASK) begin
                st_nxt.rd_data = {29'h0, st_r.irq_mask};
            end else if (addr_in == `LSW_REG_PARTNER) begin
                st_nxt.rd_data = {16'h0000, st_r.partner};
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            st_r <= RESET_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The PME line is open drain: it is only ever pulled low, never driven high.
    assign pme_n_out = 1'b0;
    assign pme_n_oe_out = st_r.pme_oe;
    assign rd_data_out = st_r.rd_data;
    assign flp_tx_pulse_out = flp.tx_pulse;
    assign link_ok_indicator_out = st_r.led_link;
    assign traffic_indicator_out = st_r.led_traffic;
    assign speed_indicator_out = st_r.led_speed;
    assign collision_or_wake_mode_indicator_out = st_r.led_mode;
    assign wake_conn_out = st_r.wake_conn;
    assign speed100_out = st_r.mode[1];
    assign full_duplex_out = st_r.mode[0];
    assign irq_out = st_r.irq;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    property p_best_mode;
        (st_r.an == LSW_AN_LISTEN && flp.rx_valid && common[3] && !restart)
            |=> speed100_out && full_duplex_out && st_r.an == LSW_AN_RESOLVED;
    endproperty
    a_best_mode: assert property (p_best_mode) else $error("best mode not chosen");

    property p_tx_half;
        (st_r.an == LSW_AN_LISTEN && flp.rx_valid && common[2] && !common[3]
            && !restart) |=> speed100_out && !full_duplex_out;
    endproperty
    a_tx_half: assert property (p_tx_half) else $error("100 half not preferred");

    property p_parallel;
        (st_r.an == LSW_AN_LISTEN && !flp.rx_valid && par_link_in && !restart)
            |=> !full_duplex_out && st_r.parallel && speed100_out == $past(par_speed100_in);
    endproperty
    a_parallel: assert property (p_parallel) else $error("parallel detect wrong");

    property p_link_led;
        link_pass_in ##1 !link_pass_in |=> !link_ok_indicator_out && $past(link_ok_indicator_out);
    endproperty
    a_link_led: assert property (p_link_led) else $error("link indicator stale");

    property p_traffic;
        (rx_active_in || tx_active_in) |=> traffic_indicator_out;
    endproperty
    a_traffic: assert property (p_traffic) else $error("traffic not shown");

    property p_speed_led;
        speed_indicator_out |-> link_ok_indicator_out && speed100_out;
    endproperty
    a_speed_led: assert property (p_speed_led) else $error("speed lit wrongly");

    property p_collision;
        (!low_power_in && collision_in) |=> collision_or_wake_mode_indicator_out;
    endproperty
    a_collision: assert property (p_collision) else $error("collision not shown");

    property p_wake_mode;
        (low_power_in && !st_r.pme_en && !st_r.conn_en)
            |=> !collision_or_wake_mode_indicator_out;
    endproperty
    a_wake_mode: assert property (p_wake_mode) else $error("wake mode shown unarmed");

    property p_wake_pme;
        (wake_frame_in && st_r.pme_en && !wr_ctrl) |=> pme_n_oe_out;
    endproperty
    a_wake_pme: assert property (p_wake_pme) else $error("PME not pulled");

    property p_wake_conn;
        (remote_wake_pkt_in && st_r.conn_en && !wr_ctrl) |=> wake_conn_out;
    endproperty
    a_wake_conn: assert property (p_wake_conn) else $error("wake line not raised");

    property p_wake_hold;
        (pme_n_oe_out && !pme_ack_in && !wr_in) [*2] |=> st_r.wake_pend;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake dropped early");

    property p_pme_gate;
        pme_n_oe_out |-> $past(st_r.pme_en) && $past(st_r.wake_pend || wake_event);
    endproperty
    a_pme_gate: assert property (p_pme_gate) else $error("PME without cause");

    c_resolved: cover property (st_r.an == LSW_AN_LISTEN ##1 st_r.an == LSW_AN_RESOLVED);
    c_parallel: cover property (st_r.an == LSW_AN_PARALLEL);
    c_wake_ack: cover property (pme_n_oe_out ##1 pme_ack_in ##1 !pme_n_oe_out);

endmodule

// >>> include/lsw_flp_if.sv
// Carrier between the negotiation controller and the pulse burst engine.
`timescale 1ns/1ps
interface lsw_flp_if;
    logic        rx_valid;
    logic [15:0] rx_word;
    logic        tx_start;
    logic [15:0] tx_word;
    logic        tx_busy;
    logic        tx_pulse;

    modport eng (output rx_valid, output rx_word, output tx_busy, output tx_pulse,
                 input tx_start, input tx_word);
    modport ctl (input rx_valid, input rx_word, input tx_busy, input tx_pulse,
                 output tx_start, output tx_word);
endinterface

// >>> include/lsw_map.svh
// Offsets, field positions, reset values and timing counts for the link status block.
`ifndef LSW_MAP_SVH
`define LSW_MAP_SVH

`define LSW_FLP_CLOCKS    5'h11
`define LSW_FLP_DATA      5'h10
`define LSW_FLP_PULSES    6'h21
`define LSW_FLP_LAST_SLOT 6'h20
`define LSW_SELECTOR      5'h01

`define LSW_CLK_MHZ       50
`define LSW_SLOT_NS       62500
`define LSW_SLOT_CYC      ((`LSW_SLOT_NS * `LSW_CLK_MHZ) / 1000)
`define LSW_GAP_NS        150000
`define LSW_GAP_CYC       ((`LSW_GAP_NS * `LSW_CLK_MHZ) / 1000)

`define LSW_ADDR_W        8
`define LSW_REG_CTRL      8'h00
`define LSW_REG_STATUS    8'h04
`define LSW_REG_IRQ_STAT  8'h08
`define LSW_REG_IRQ_MASK  8'h0C
`define LSW_REG_PARTNER   8'h10

`define LSW_CTRL_ADV_LSB  0
`define LSW_CTRL_PME_EN   4
`define LSW_CTRL_CONN_EN  5
`define LSW_CTRL_RESTART  6
`define LSW_ADV_RESET     4'hF

`define LSW_ST_WAKE       4
`define LSW_ABIL_LSB      5

`define LSW_IRQ_LINK      0
`define LSW_IRQ_AN        1
`define LSW_IRQ_WAKE      2
`define LSW_IRQ_W         3

`endif

// >>> include/lsw_pkg.sv
// Types shared by the link status and wake modules.
package lsw_pkg;

    typedef enum logic [1:0] {
        LSW_AN_IDLE     = 2'h0,
        LSW_AN_LISTEN   = 2'h1,
        LSW_AN_RESOLVED = 2'h3,
        LSW_AN_PARALLEL = 2'h2
    } lsw_an_state_type;

    // Bit 1 is the 100 Mbps flag, bit 0 the full duplex flag.
    typedef enum logic [1:0] {
        LSW_MODE_10HD  = 2'h0,
        LSW_MODE_10FD  = 2'h1,
        LSW_MODE_TXHD  = 2'h2,
        LSW_MODE_TXFD  = 2'h3
    } lsw_mode_type;

    typedef struct packed {
        logic [4:0]  rx_cnt;
        logic [5:0]  rx_pulses;
        logic        rx_seen;
        logic [15:0] rx_word;
        logic        rx_valid;
        logic [15:0] rx_timer;
        logic        tx_busy;
        logic [5:0]  tx_slot;
        logic [15:0] tx_timer;
        logic [15:0] tx_word;
        logic        tx_pulse;
    } lsw_eng_state_type;

    typedef struct packed {
        lsw_an_state_type an;
        lsw_mode_type     mode;
        logic             parallel;
        logic [15:0]      partner;
        logic [3:0]       adv;
        logic             pme_en;
        logic             conn_en;
        logic             link_prev;
        logic             wake_pend;
        logic [2:0]       irq_stat;
        logic [2:0]       irq_mask;
        logic             tx_start;
        logic [31:0]      rd_data;
        logic             led_link;
        logic             led_traffic;
        logic             led_speed;
        logic             led_mode;
        logic             pme_oe;
        logic             wake_conn;
        logic             irq;
    } lsw_top_state_type;

endpackage

// >>> tb/lsw_partner.sv
// Link partner model that sends negotiation pulse bursts towards the block.
`timescale 1ns/1ps
module lsw_partner (
    input  wire logic ref_clk_in,
    output logic      clk_pulse_out,
    output logic      data_pulse_out
);
    initial begin
        clk_pulse_out  = 1'b0;
        data_pulse_out = 1'b0;
    end

    // Clock pulses come every eight cycles, well inside the gap limit of the small build.
    task automatic send_burst(input logic [15:0] word);
        int i;
        for (i = 0; i < 17; i++) begin
            @(posedge ref_clk_in);
            clk_pulse_out <= 1'b1;
            @(posedge ref_clk_in);
            clk_pulse_out <= 1'b0;
            repeat (3) @(posedge ref_clk_in);
            if (i < 16) begin
                data_pulse_out <= word[i];
                @(posedge ref_clk_in);
                data_pulse_out <= 1'b0;
            end
            repeat (2) @(posedge ref_clk_in);
        end
    endtask
endmodule

// >>> tb/tb_link_status_and_wake_indication.sv
// Self-checking bench for the link status, indicator and wake-up block.
`timescale 1ns/1ps
`include "lsw_map.svh"
module tb_link_status_and_wake_indication;
    import lsw_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wr_data_in = 32'h0;
    logic [31:0] rd_data_out;
    logic        wr_in = 0, rd_in = 0, link_pass_in = 0, par_link_in = 0, par_speed100_in = 0;
    logic        rx_active_in = 0, tx_active_in = 0, collision_in = 0, low_power_in = 0;
    logic        remote_wake_pkt_in = 0, wake_frame_in = 0, pme_ack_in = 0;
    logic        flp_clk, flp_data, flp_tx_pulse_out, link_ok_indicator_out;
    logic        traffic_indicator_out, speed_indicator_out, collision_or_wake_mode_indicator_out;
    logic        pme_n_out, pme_n_oe_out, wake_conn_out, speed100_out, full_duplex_out, irq_out;
    int          n_fail = 0;
    int          n_compared = 0;
    int          n_txp = 0;
    logic [31:0] d;

    always #10 ref_clk_in = ~ref_clk_in;

    // Every transmitted burst pulse is one cycle wide, so each high sample is one pulse.
    always @(posedge ref_clk_in) begin
        if (flp_tx_pulse_out === 1'b1) begin
            n_txp <= n_txp + 1;
        end
    end

    lsw_partner partner (.ref_clk_in, .clk_pulse_out(flp_clk), .data_pulse_out(flp_data));
    lsw_top #(.SLOT_CYC(4), .GAP_CYC(20)) uut (
        .ref_clk_in, .rstn_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
        .flp_clk_pulse_in(flp_clk), .flp_data_pulse_in(flp_data), .flp_tx_pulse_out,
        .link_pass_in, .par_link_in, .par_speed100_in, .rx_active_in, .tx_active_in,
        .collision_in, .low_power_in, .remote_wake_pkt_in, .wake_frame_in, .pme_ack_in,
        .link_ok_indicator_out, .traffic_indicator_out, .speed_indicator_out,
        .collision_or_wake_mode_indicator_out, .pme_n_out, .pme_n_oe_out, .wake_conn_out,
        .speed100_out, .full_duplex_out, .irq_out);

    task automatic close_out;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_in);
        addr_in <= a;
        wr_data_in <= v;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 v = rd_data_out;
    endtask

    task automatic pulse_ack;
        @(posedge ref_clk_in);
        pme_ack_in <= 1'b1;
        @(posedge ref_clk_in);
        pme_ack_in <= 1'b0;
        cyc(3);
    endtask

    task automatic t_indicators;
        @(posedge ref_clk_in);
        link_pass_in <= 1'b1;
        rx_active_in <= 1'b1;
        collision_in <= 1'b1;
        cyc(1);
        chk("link_ok", 1, link_ok_indicator_out);
        chk("traffic_rx", 1, traffic_indicator_out);
        chk("coll", 1, collision_or_wake_mode_indicator_out);
        rx_active_in <= 1'b0;
        tx_active_in <= 1'b1;
        collision_in <= 1'b0;
        cyc(1);
        chk("traffic_tx", 1, traffic_indicator_out);
        chk("coll_off", 0, collision_or_wake_mode_indicator_out);
        tx_active_in <= 1'b0;
        link_pass_in <= 1'b0;
        cyc(1);
        chk("traffic_off", 0, traffic_indicator_out);
        chk("link_fail", 0, link_ok_indicator_out);
    endtask

    task automatic t_parallel;
        @(posedge ref_clk_in);
        link_pass_in <= 1'b1;
        par_link_in <= 1'b1;
        par_speed100_in <= 1'b1;
        cyc(5);
        chk("par_mode", 2'b10, {speed100_out, full_duplex_out});
        chk("speed_led", 1, speed_indicator_out);
        link_pass_in <= 1'b0;
        par_link_in <= 1'b0;
        cyc(2);
        chk("speed_led_nolink", 0, speed_indicator_out);
    endtask

    task automatic t_negotiate;
        logic [3:0]   adv_t[4] = '{4'hF, 4'hF, 4'h3, 4'hF};
        logic [3:0]   abil_t[4] = '{4'hF, 4'h5, 4'hF, 4'h1};
        lsw_mode_type exp_t[4] = '{LSW_MODE_TXFD, LSW_MODE_TXHD, LSW_MODE_10FD, LSW_MODE_10HD};
        int           n_tx_base;
        for (int k = 0; k < 4; k++) begin
            wr(`LSW_REG_CTRL, {24'h0, 4'h7, adv_t[k]});
            partner.send_burst({7'h0, abil_t[k], `LSW_SELECTOR});
            cyc(2);
            chk("an_mode", exp_t[k], {speed100_out, full_duplex_out});
        end
        // Once resolved no burst is started, so the sender is quiet before the restart.
        cyc(140);
        n_tx_base = n_txp;
        wr(`LSW_REG_CTRL, 32'h71);
        cyc(20);
        // A parallel link ends the listen phase, so exactly one burst goes out.
        par_link_in <= 1'b1;
        cyc(140);
        par_link_in <= 1'b0;
        chk("tx_pulses", 19, n_txp - n_tx_base);
    endtask

    task automatic t_wake;
        pulse_ack();
        chk("pme_idle", 0, pme_n_oe_out);
        for (int s = 0; s < 3; s++) begin
            @(posedge ref_clk_in);
            wake_frame_in <= (s == 0);
            remote_wake_pkt_in <= (s == 1);
            link_pass_in <= (s == 2);
            @(posedge ref_clk_in);
            wake_frame_in <= 1'b0;
            remote_wake_pkt_in <= 1'b0;
            cyc(2);
            chk("pme_oe", 1, pme_n_oe_out);
            chk("pme_n", 0, pme_n_out);
            chk("wake_conn", 1, wake_conn_out);
            cyc(6);
            chk("wake_held", 1, wake_conn_out);
            pulse_ack();
            chk("pme_cleared", 0, pme_n_oe_out);
        end
        link_pass_in <= 1'b0;
        wr(`LSW_REG_CTRL, 32'h0F);
        cyc(2);
        pulse_ack();
        low_power_in <= 1'b1;
        collision_in <= 1'b1;
        wake_frame_in <= 1'b1;
        @(posedge ref_clk_in);
        wake_frame_in <= 1'b0;
        cyc(3);
        chk("pme_disabled", 0, pme_n_oe_out);
        chk("conn_disabled", 0, wake_conn_out);
        chk("lp_unarmed", 0, collision_or_wake_mode_indicator_out);
        wr(`LSW_REG_CTRL, 32'h3F);
        cyc(2);
        chk("lp_armed", 1, collision_or_wake_mode_indicator_out);
        low_power_in <= 1'b0;
        collision_in <= 1'b0;
        pulse_ack();
    endtask

    task automatic t_irq;
        wr(`LSW_REG_IRQ_STAT, 32'h7);
        wr(`LSW_REG_IRQ_MASK, 32'h4);
        wake_frame_in <= 1'b1;
        @(posedge ref_clk_in);
        wake_frame_in <= 1'b0;
        cyc(3);
        chk("irq_on", 1, irq_out);
        rd(`LSW_REG_IRQ_STAT, d);
        chk("irq_stat", 32'h4, d);
        wr(`LSW_REG_IRQ_STAT, 32'h4);
        cyc(2);
        chk("irq_cleared", 0, irq_out);
        rd(8'h20, d);
        chk("unmapped", 32'h0, d);
    endtask

    initial begin
        #200000;
        n_fail++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        rd(`LSW_REG_CTRL, d);
        chk("ctrl_reset", 32'h3F, d);
        t_indicators();
        t_parallel();
        t_negotiate();
        t_wake();
        t_irq();
        close_out();
    end
endmodule
